// [interrupt_priority_fields_tb.sv]
`timescale 1ns/1ps
module interrupt_priority_fields_tb;
   import ipf_pkg::*;
   typedef struct {logic [3:0] a; logic [31:0] d; logic [3:0] s; logic [1:0] b; logic [31:0] r;
      logic [1:0] q;} ipf_row_s;
   logic aclk, aresetn, awv, awr, wv, wr, bv, bq, arv, arr, rv, rq;
   logic [3:0] awa, ara, ws;
   logic [31:0] wd, rdat, rd;
   logic [1:0] br, rs, rr, rrs;
   logic [2:0] pu, pp, pc2, pc1, pd7, pd6, top_lvl;
   logic [5:0] src_enable;
   int bad_count, checked;
   // Gap bits written high must read back low
   ipf_row_s rows [6] = '{'{4'h0, 32'hffffffff, 4'hf, 2'h0, 32'h77, 2'h0},
      '{4'h4, 32'hffff9ab0, 4'hf, 2'h0, 32'h1230, 2'h0},
      '{4'h0, 32'h15, 4'hf, 2'h0, 32'h15, 2'h0},
      '{4'h4, 32'hee56, 4'h1, 2'h0, 32'h1256, 2'h0},
      '{4'h8, 32'h0, 4'hf, IPF_RESP_SLVERR, 32'h3f, 2'h0},
      '{4'hc, 32'h0, 4'hf, IPF_RESP_SLVERR, 32'h0, IPF_RESP_SLVERR}};
   ipf_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bq), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rq), .uart1_error_prio(pu), .pwm_fault_b_prio(pp),
      .can2_tx_prio(pc2), .can1_tx_prio(pc1), .dma_ch7_done_prio(pd7), .dma_ch6_done_prio(pd6),
      .src_enable(src_enable));
   ipf_arb_model u_arb (.lvl({pc2, pc1, pd7, pd6, pu, pp}), .en(src_enable), .top_lvl(top_lvl));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic give_verdict;
      $display("Checked %0d, bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // A wait that used its bound ends the run
   task automatic wt(input int k);
      if (k >= 50) begin
         bad_count++;
         give_verdict;
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      int k;
      @(posedge aclk);
      awa <= a;
      wd <= d;
      ws <= s;
      {awv, wv, bq} <= 3'h7;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         if (bv) break;
      end
      wt(k);
      r = br;
      bq <= 1'b0;
   endtask
   task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] q);
      int k;
      @(posedge aclk);
      ara <= a;
      {arv, rq} <= 2'h3;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      wt(k);
      d = rdat;
      q = rr;
      rq <= 1'b0;
   endtask
   initial begin
      aresetn = 1'b0;
      {awv, wv, bq, arv, rq} = '0;
      {awa, ara, ws, wd} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         axw(rows[i].a, rows[i].d, rows[i].s, rs);
         cmp("bresp", {30'h0, rows[i].b}, {30'h0, rs});
         axr(rows[i].a, rd, rrs);
         cmp("rdata", rows[i].r, rd);
         cmp("rresp", {30'h0, rows[i].q}, {30'h0, rrs});
      end
      cmp("fields", 32'h0ab8d, {14'h0, pc2, pc1, pd7, pd6, pu, pp});
      cmp("top_lvl", 32'h6, {29'h0, top_lvl});
      cmp("dma6", 32'h6, {29'h0, pd6});
      // Reset again in mid-run
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      axr(IPF_CAN_DMA_OFS, rd, rrs);
      cmp("reset second", 32'h4444, rd);
      cmp("rresp second", 32'h0, {30'h0, rrs});
      cmp("reset fields", 32'h24924, {14'h0, pc2, pc1, pd7, pd6, pu, pp});
      axr(IPF_UART_FAULT_OFS, rd, rrs);
      cmp("reset first", 32'h44, rd);
      axw(IPF_UART_FAULT_OFS, 32'h0, 4'hf, rs);
      repeat (2) @(posedge aclk);
      cmp("src_enable", 32'h3c, {26'h0, src_enable});
      give_verdict;
   end
endmodule

// [ipf_arb_model.sv]
`timescale 1ns/1ps
// Arbiter stand-in, highest enabled level wins
module ipf_arb_model (
   // Levels, source 0 lowest bits
   input wire logic [17:0] lvl,
   input wire logic [5:0] en,
   // Winning level
   output logic [2:0] top_lvl
);
   always_comb begin
      top_lvl = 3'h0;
      for (int i = 0; i < 6; i++) begin
         if (en[i] && lvl[3*i+:3] > top_lvl) top_lvl = lvl[3*i+:3];
      end
   end
endmodule

// [ipf_field_if.sv]
`timescale 1ns/1ps
// Write strobe, data and stored value for one priority field
interface ipf_field_if;
   logic we;
   logic [2:0] wdata;
   logic [2:0] value;
   modport owner (input we, input wdata, output value);
   modport user (output we, output wdata, input value);
endinterface

// [ipf_pkg.sv]
package ipf_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [3:0] IPF_UART_FAULT_OFS = 4'h0;
   localparam logic [3:0] IPF_CAN_DMA_OFS = 4'h4;
   localparam logic [3:0] IPF_STATUS_OFS = 4'h8;
   localparam int IPF_ADDR_W = 4;
   // Field width and positions
   localparam int IPF_PRIO_W = 3;
   localparam int IPF_NUM_FIELDS = 6;
   localparam int IPF_POS_PWM_FAULT_B = 0;
   localparam int IPF_POS_UART1_ERR = 4;
   localparam int IPF_POS_DMA6 = 0;
   localparam int IPF_POS_DMA7 = 4;
   localparam int IPF_POS_CAN1 = 8;
   localparam int IPF_POS_CAN2 = 12;
   // Field value meanings
   localparam logic [2:0] IPF_PRIO_RESET = 3'h4;
   localparam logic [2:0] IPF_PRIO_OFF = 3'h0;
   localparam logic [2:0] IPF_PRIO_MAX = 3'h7;
   // AXI responses
   localparam logic [1:0] IPF_RESP_OKAY = 2'h0;
   localparam logic [1:0] IPF_RESP_SLVERR = 2'h2;
   typedef logic [2:0] ipf_prio_t;
endpackage

// [ipf_prio_field.sv]
`timescale 1ns/1ps
// One 3-bit priority field with its power-on value
module ipf_prio_field
   import ipf_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Field access
   ipf_field_if.owner fld
);
   ipf_prio_t value_q;

   // Storage, loads the mid priority on reset
   // reset to four
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value_q <= IPF_PRIO_RESET;
      end else if (fld.we) begin
         value_q <= fld.wdata;
      end
   end

   assign fld.value = value_q;
endmodule

// [ipf_regs.sv]
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - Each priority field is three bits; value 7 is highest priority.
// - Value 1 is lowest enabled priority, 2..6 between, 0 disables source.
// - First register bits 6:4 hold the UART1 error priority.
// - First register bits 2:0 hold PWM fault B priority; bits 3,7 read zero.
// - Second register: CAN2 14:12, CAN1 10:8, DMA7 6:4, DMA6 2:0; gaps zero.
module ipf_regs
   import ipf_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic [ipf_pkg::IPF_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address channel
   input wire logic [ipf_pkg::IPF_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Field values to the arbiter
   output logic [2:0] uart1_error_prio,
   output logic [2:0] pwm_fault_b_prio,
   output logic [2:0] can2_tx_prio,
   output logic [2:0] can1_tx_prio,
   output logic [2:0] dma_ch7_done_prio,
   output logic [2:0] dma_ch6_done_prio,
   // Per-source enable, zero priority disables
   output logic [5:0] src_enable
);
   import ipf_pkg::*;

   // Field order: 0 pwm_fault_b, 1 uart1_err, 2 dma6, 3 dma7, 4 can1, 5 can2
   localparam int FREG [IPF_NUM_FIELDS] = '{0, 0, 1, 1, 1, 1};
   localparam int FPOS [IPF_NUM_FIELDS] = '{IPF_POS_PWM_FAULT_B, IPF_POS_UART1_ERR,
      IPF_POS_DMA6, IPF_POS_DMA7, IPF_POS_CAN1, IPF_POS_CAN2};

   // Write slot, address and data held apart until both arrive
   logic [IPF_ADDR_W-1:0] awaddr_q;
   logic aw_held_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_held_q;

   // Commit strobe and its decode
   logic wr_go;
   logic wr_hit;

   // Field values and assembled register images
   logic [2:0] fval [IPF_NUM_FIELDS];
   logic [15:0] reg0;
   logic [15:0] reg1;

   // Address decode, used for both reads and writes
   function automatic logic [1:0] ipf_decode(input logic [IPF_ADDR_W-1:0] a);
      logic [1:0] r;
      r = 2'h3;
      if (a == IPF_UART_FAULT_OFS) begin
         r = 2'h0;
      end else if (a == IPF_CAN_DMA_OFS) begin
         r = 2'h1;
      end else if (a == IPF_STATUS_OFS) begin
         r = 2'h2;
      end
      return r;
   endfunction

   // Write address capture, either order with data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_q <= 1'b0;
      end
   end

   // Write data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_q <= 1'b0;
      end
   end

   // Commit once both halves held and no response pending
   // Holding off while bvalid stands keeps one response in flight
   assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_hit = ipf_decode(awaddr_q) < 2'h2;

   // Ready only while the slot is empty
   // Registered ready costs a cycle per write, keeps outputs glitch free
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Write response; status register is read only, so it errors
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= IPF_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? IPF_RESP_OKAY : IPF_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < IPF_NUM_FIELDS; gi++) begin : g_field
         ipf_field_if fif ();
         // Each field is written when the byte lane holding its bits is strobed
         // A write without the lane strobe leaves the field as it was
         assign fif.we = wr_go && (ipf_decode(awaddr_q) == 2'(FREG[gi])) &&
            wstrb_q[FPOS[gi] / 8];
         assign fif.wdata = wdata_q[FPOS[gi] +: IPF_PRIO_W];
         assign fval[gi] = fif.value;
         ipf_prio_field u_field (
            .aclk(aclk),
            .aresetn(aresetn),
            .fld(fif)
         );
      end
   endgenerate

   // fault b at 2:0, gaps zero
   assign reg0 = {9'h0, fval[1], 1'b0, fval[0]};
   assign reg1 = {1'b0, fval[5], 1'b0, fval[4], 1'b0, fval[3], 1'b0, fval[2]};

   // Read channel, one cycle after address taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= IPF_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= IPF_RESP_OKAY;
         unique case (ipf_decode(s_axi_araddr))
            2'h0: s_axi_rdata <= {16'h0000, reg0};
            2'h1: s_axi_rdata <= {16'h0000, reg1};
            2'h2: s_axi_rdata <= {26'h0, src_enable};
            // Unmapped offset answers an error with zero data
            2'h3: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= IPF_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // Registered copies of the fields for the arbiter
   // Enables change in the same cycle as the fields, so they never disagree
   // zero disables, one lowest
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_fault_b_prio <= IPF_PRIO_RESET;
         uart1_error_prio <= IPF_PRIO_RESET;
         dma_ch6_done_prio <= IPF_PRIO_RESET;
         dma_ch7_done_prio <= IPF_PRIO_RESET;
         can1_tx_prio <= IPF_PRIO_RESET;
         can2_tx_prio <= IPF_PRIO_RESET;
         src_enable <= '1;
      end else begin
         pwm_fault_b_prio <= fval[0];
         uart1_error_prio <= fval[1];
         dma_ch6_done_prio <= fval[2];
         dma_ch7_done_prio <= fval[3];
         can1_tx_prio <= fval[4];
         can2_tx_prio <= fval[5];
         for (int i = 0; i < IPF_NUM_FIELDS; i++) begin
            src_enable[i] <= fval[i] != IPF_PRIO_OFF;
         end
      end
   end
endmodule

// [ipf_regs_sva.sv]
`timescale 1ns/1ps
// Port-level checks of the priority fields
module ipf_regs_sva
   import ipf_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire logic [ipf_pkg::IPF_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   // Fields
   input wire logic [2:0] uart1_error_prio,
   input wire logic [2:0] pwm_fault_b_prio,
   input wire logic [2:0] can2_tx_prio,
   input wire logic [2:0] can1_tx_prio,
   input wire logic [2:0] dma_ch7_done_prio,
   input wire logic [2:0] dma_ch6_done_prio,
   input wire logic [5:0] src_enable
);
   logic [3:0] ra_q;
   logic [17:0] f;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Fields packed in enable bit order
   assign f = {can2_tx_prio, can1_tx_prio, dma_ch7_done_prio, dma_ch6_done_prio, uart1_error_prio, pwm_fault_b_prio};
   // Address of the read in flight
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
   end
   AST_RESET_FOUR: assert property ($rose(aresetn) |-> f == {6{3'h4}})
      else $error("field not four after reset");
   AST_ZERO_OFF: assert property ($stable(f) |-> src_enable == {|f[17:15], |f[14:12], |f[11:9],
      |f[8:6], |f[5:3], |f[2:0]}) else $error("enable does not follow field");
   AST_UART_BITS: assert property (s_axi_rvalid && ra_q == IPF_UART_FAULT_OFS
      |-> s_axi_rdata[31:4] == {25'h0, f[5:3]}) else $error("uart field misplaced");
   AST_PWM_BITS: assert property (s_axi_rvalid && ra_q == IPF_UART_FAULT_OFS
      |-> s_axi_rdata[3:0] == {1'b0, f[2:0]}) else $error("pwm field misplaced");
   AST_SECOND_MAP: assert property (s_axi_rvalid && ra_q == IPF_CAN_DMA_OFS |-> s_axi_rdata ==
      {17'h0, f[17:15], 1'b0, f[14:12], 1'b0, f[11:9], 1'b0, f[8:6]}) else $error("second map wrong");
   AST_WRITE_ONLY: assert property (!$stable(f) |-> $past(s_axi_bvalid))
      else $error("field moved without write");
endmodule

bind ipf_regs ipf_regs_sva u_sva (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_bvalid, .uart1_error_prio, .pwm_fault_b_prio, .can2_tx_prio, .can1_tx_prio,
   .dma_ch7_done_prio, .dma_ch6_done_prio, .src_enable);
